// ===== hdl/sitc_consts.svh
`ifndef SITC_CONSTS_SVH
`define SITC_CONSTS_SVH
// ****************************************
// Command codes and mode encodings
// ****************************************
`define SITC_CMD_CM_CLEAR      8'h70
`define SITC_CMD_TS_INIT       8'h68
`define SITC_CMD_CM_WR_MASK    8'hF0
`define SITC_MODE_CM_RESET     2'b00
`define SITC_MODE_CM_INIT      2'b10
`define SITC_MODE_NORMAL       2'b11
`define SITC_CODE_UNASSIGNED   4'h0
`define SITC_CODE_PREPROC      4'h8
// ****************************************
// Timing
// ****************************************
`define SITC_CM_CLEAR_CYC      256
`define SITC_TS_INIT_CYC       1035
`define SITC_CM_ACC_CYC        4
`define SITC_CM_ACC_FAST_HALF  5
`define SITC_TIMER_STEP_US     250
`define SITC_REF_CLK_MHZ       40
`define SITC_TIMER_STEP_CYC    (`SITC_TIMER_STEP_US * `SITC_REF_CLK_MHZ)
`define SITC_RESET_MIN_TRUNK   4
// ****************************************
// Geometry
// ****************************************
`define SITC_CM_DEPTH          256
`define SITC_CM_AW             8
`define SITC_TS_DEPTH          128
`endif

// ===== hdl/sitc_pkg.sv
package sitc_pkg;
  typedef enum logic [4:0] {
    SITC_IDLE    = 5'b00001,
    SITC_CLEAR   = 5'b00010,
    SITC_TSINIT  = 5'b00100,
    SITC_SINGLE  = 5'b01000,
    SITC_DONE    = 5'b10000
  } sitc_mem_e;
  typedef logic [11:0] sitc_cm_word_t;
endpackage

// ===== hdl/sitc_mem.sv
`timescale 1ns/1ps
module sitc_mem #(
  parameter int DEPTH = 256,
  parameter int AW    = 8,
  parameter int DW    = 12
) (
  // Clock
  input  wire logic          ref_clk,
  // Write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // Read port
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  // No reset: contents survive hardware reset by design
  logic [DW-1:0] mem [DEPTH];
  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end
  always_ff @(posedge ref_clk) begin
    rdata <= mem[raddr];
  end
endmodule // sitc_mem

// ===== hdl/sitc_ctrl.sv
`timescale 1ns/1ps
`include "sitc_consts.svh"
// How it works
// - Free-running timer, period 250us steps to 32ms
// - Timer tick feeds debounce and multiframe marker
// - Detect clock/power loss, request reinitialization
// - Reset held four trunk clocks resets registers
// - No clock or sync output during reset
// - Reset leaves memories; host must clear them
// - Command 70h in mode 00 clears memory
// - Busy flag high while memory command runs
// - Even downstream code 1000 sends data field
// - Even upstream code 1000 holds expected value
// - Odd pre-processed slot selects one of four
// - Mode 10 shortens access to 2.5 cycles
// - Command 68h loads tristate field, 1035 cycles
// - Tristate field picks drive or high impedance
// - Trunk standby keeps trunk drivers released
// - Mode 11 enables framing interrupt and sync
// - Interface standby release enables interface outputs
// - Output style selects open drain or tristate
// - Mode holds handshake, loop and bank bits
// - Configuration writes accepted in every mode
// - Inactive downstream bits: high-Z or one
module sitc_ctrl #(
  parameter int TIMER_STEP_CYC = `SITC_TIMER_STEP_CYC,
  parameter int CM_CLEAR_CYC   = `SITC_CM_CLEAR_CYC,
  parameter int TS_INIT_CYC    = `SITC_TS_INIT_CYC
) (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rstn,
  input  wire logic                 reset_pin,
  input  wire logic                 trunk_clock,
  // Host command port
  input  wire logic                 cmd_wr,
  input  wire logic [7:0]           memory_command_reg,
  input  wire logic [7:0]           memory_address_reg,
  input  wire logic [7:0]           memory_data_reg,
  input  wire logic [7:0]           timer_period,
  // Operation mode
  input  wire logic [1:0]           operation_mode_bits,
  input  wire logic                 trunk_standby_release,
  input  wire logic                 cfg_if_standby_release,
  input  wire logic                 output_style_bit,
  input  wire logic                 trunk_test_loop,
  input  wire logic                 monitor_handshake_select,
  input  wire logic                 register_bank_select,
  input  wire logic                 cfg_wr,
  input  wire logic [7:0]           cfg_data,
  // Supervision and trunk state
  input  wire logic                 supply_fail,
  input  wire logic                 trunk_frame_ok,
  input  wire logic                 trunk_irq_mask,
  input  wire logic [6:0]           trunk_slot,
  input  wire logic                 trunk_bit_in,
  input  wire logic                 cfg_slot_active,
  input  wire logic                 cfg_bit_in,
  input  wire logic                 dclk_gen,
  input  wire logic                 fsync_gen,
  input  wire logic                 dclk_is_output,
  // Status
  output logic                      memory_access_busy,
  output logic                      timer_irq,
  output logic                      debounce_tick,
  output logic                      multiframe_mark,
  output logic                      reinit_request,
  output logic                      trunk_framing_irq,
  output logic                      trunk_sync_status,
  output logic [4:0]                mode_flags,
  output logic [7:0]                cfg_reg,
  // Pins
  output logic                      data_clock_out,
  output logic                      data_clock_oe,
  output logic                      frame_sync_out,
  output logic                      frame_sync_oe,
  output logic                      trunk_data_out,
  output logic                      trunk_data_oe,
  output logic                      cfg_data_out,
  output logic                      cfg_data_oe,
  // Pre-processed slot view
  output sitc_pkg::sitc_cm_word_t   cm_rd_word
);
  import sitc_pkg::*;

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [1:0] rpin_s_q;
  logic [1:0] tclk_s_q;
  logic [1:0] fail_s_q;
  logic       tclk_prev_q;
  always_ff @(posedge ref_clk) begin
    rpin_s_q <= {rpin_s_q[0], reset_pin};
    tclk_s_q <= {tclk_s_q[0], trunk_clock};
    fail_s_q <= {fail_s_q[0], supply_fail};
    tclk_prev_q <= tclk_s_q[1];
  end
  wire trunk_rise = tclk_s_q[1] & ~tclk_prev_q;

  // Reset pin must stay low for four trunk clocks to count
  logic [2:0] rcnt_q;
  logic       pin_rst_q;
  always_ff @(posedge ref_clk) begin
    if (!rstn || rpin_s_q[1]) begin
      rcnt_q <= 3'h0;
    end else if (trunk_rise && rcnt_q != 3'(`SITC_RESET_MIN_TRUNK)) begin
      rcnt_q <= rcnt_q + 3'h1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pin_rst_q <= 1'b0;
    end else if (rpin_s_q[1]) begin
      pin_rst_q <= 1'b0;
    end else if (rcnt_q == 3'(`SITC_RESET_MIN_TRUNK)) begin
      pin_rst_q <= 1'b1;
    end
  end
  wire srst = !rstn || pin_rst_q;

  // ****************************************
  // Periodic timer
  // ****************************************
  logic [13:0] step_q;
  logic [7:0]  per_q;
  logic [3:0]  mf_q;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      step_q <= 14'h0;
      per_q <= 8'h00;
      timer_irq <= 1'b0;
      debounce_tick <= 1'b0;
    end else begin
      timer_irq <= 1'b0;
      debounce_tick <= 1'b0;
      if (step_q == 14'(TIMER_STEP_CYC - 1)) begin
        step_q <= 14'h0;
        // Period is (timer_period[6:0]+1) x 250us, 1..128 steps
        if (per_q == {1'b0, timer_period[6:0]}) begin
          per_q <= 8'h00;
          timer_irq <= 1'b1;
          debounce_tick <= 1'b1;
        end else begin
          per_q <= per_q + 8'h01;
        end
      end else begin
        step_q <= step_q + 14'h1;
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mf_q <= 4'h0;
      multiframe_mark <= 1'b0;
    end else if (debounce_tick) begin
      mf_q <= mf_q + 4'h1;
      multiframe_mark <= 1'b1;
    end else if (fsync_gen) begin
      multiframe_mark <= 1'b0;
    end
  end

  // ****************************************
  // Supervision
  // ****************************************
  // Trunk clock silent for 16383 reference clock cycles means clock loss
  logic [13:0] idle_q;
  sitc_mem_e   state_q;
  always_ff @(posedge ref_clk) begin
    if (srst || trunk_rise) begin
      idle_q <= 14'h0;
    end else if (idle_q != 14'h3FFF) begin
      idle_q <= idle_q + 14'h1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      reinit_request <= 1'b0;
    end else if (fail_s_q[1] || idle_q == 14'h3FFF) begin
      reinit_request <= 1'b1;
    end else if (state_q == SITC_CLEAR) begin
      reinit_request <= 1'b0;
    end
  end

  // ****************************************
  // Configuration and mode
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cfg_reg <= 8'h00;
    end else if (cfg_wr) begin
      cfg_reg <= cfg_data;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mode_flags <= 5'h00;
    end else begin
      mode_flags <= {output_style_bit, cfg_if_standby_release, trunk_test_loop,
                     monitor_handshake_select, register_bank_select};
    end
  end

  // ****************************************
  // Memory command engine
  // ****************************************
  logic [10:0] cnt_q;
  logic [7:0]  addr_q;
  logic [7:0]  data_q;
  logic [3:0]  code_q;
  logic        cm_we;
  logic        ts_we;
  logic [7:0]  cm_wa;
  logic [6:0]  ts_wa;
  sitc_cm_word_t cm_wd;

  wire is_clear  = memory_command_reg == `SITC_CMD_CM_CLEAR;
  wire is_tsinit = memory_command_reg == `SITC_CMD_TS_INIT;
  wire fast      = operation_mode_bits == `SITC_MODE_CM_INIT;

  // Fast mode: alternate 2 and 3 cycles, averaging 2.5 per access
  function automatic logic [10:0] acc_len(input logic f, input logic odd);
    acc_len = f ? (odd ? 11'd2 : 11'd1) : 11'(`SITC_CM_ACC_CYC - 1);
  endfunction

  logic odd_q;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_q <= SITC_IDLE;
      cnt_q <= 11'h0;
      addr_q <= 8'h00;
      data_q <= 8'h00;
      code_q <= 4'h0;
      odd_q <= 1'b0;
    end else begin
      case (state_q)
        SITC_IDLE: begin
          // Writes while busy never reach this state: ignored
          if (cmd_wr) begin
            data_q <= memory_data_reg;
            addr_q <= memory_address_reg;
            code_q <= memory_command_reg[3:0];
            cnt_q <= 11'h0;
            if (is_clear && operation_mode_bits == `SITC_MODE_CM_RESET) begin
              state_q <= SITC_CLEAR;
            end else if (is_tsinit && operation_mode_bits == `SITC_MODE_NORMAL) begin
              state_q <= SITC_TSINIT;
            end else if ((memory_command_reg & `SITC_CMD_CM_WR_MASK) == `SITC_CMD_CM_CLEAR) begin
              cnt_q <= acc_len(fast, odd_q);
              odd_q <= ~odd_q;
              state_q <= SITC_SINGLE;
            end
          end
        end
        SITC_CLEAR: begin
          cnt_q <= cnt_q + 11'h1;
          if (cnt_q == 11'(CM_CLEAR_CYC - 1)) begin
            state_q <= SITC_DONE;
          end
        end
        SITC_TSINIT: begin
          cnt_q <= cnt_q + 11'h1;
          if (cnt_q == 11'(TS_INIT_CYC - 1)) begin
            state_q <= SITC_DONE;
          end
        end
        SITC_SINGLE: begin
          if (cnt_q == 11'h0) begin
            state_q <= SITC_DONE;
          end else begin
            cnt_q <= cnt_q - 11'h1;
          end
        end
        SITC_DONE: begin
          state_q <= SITC_IDLE;
        end
        default: begin
          state_q <= SITC_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    cm_we = 1'b0;
    ts_we = 1'b0;
    cm_wa = addr_q;
    ts_wa = cnt_q[6:0];
    cm_wd = {code_q, data_q};
    case (state_q)
      SITC_CLEAR: begin
        cm_we = 1'b1;
        cm_wa = cnt_q[7:0];
        cm_wd = {`SITC_CODE_UNASSIGNED, data_q};
      end
      SITC_TSINIT: begin
        ts_we = cnt_q < 11'(`SITC_TS_DEPTH);
      end
      SITC_SINGLE: begin
        // Code 1000 on even slots keeps the data field
        cm_we = cnt_q == 11'h0;
      end
      default: begin
        cm_we = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      memory_access_busy <= 1'b0;
    end else begin
      // Refused commands must not flash busy
      memory_access_busy <= (state_q == SITC_IDLE && cmd_wr &&
                             ((is_tsinit && operation_mode_bits == `SITC_MODE_NORMAL) ||
                              memory_command_reg[7:4] == 4'h7))
                            || (state_q != SITC_IDLE && state_q != SITC_DONE);
    end
  end

  sitc_mem #(.DEPTH(`SITC_CM_DEPTH), .AW(`SITC_CM_AW), .DW(12)) u_cm (
    .ref_clk (ref_clk),
    .we      (cm_we),
    .waddr   (cm_wa),
    .wdata   (cm_wd),
    .raddr   (memory_address_reg),
    .rdata   (cm_rd_word)
  );

  // Tristate field: one bit per trunk slot, untouched by reset
  logic [`SITC_TS_DEPTH-1:0] ts_field;
  always_ff @(posedge ref_clk) begin
    if (ts_we) begin
      ts_field[ts_wa] <= |data_q[3:0];
    end
  end

  // ****************************************
  // Trunk and interface status
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      trunk_sync_status <= 1'b0;
      trunk_framing_irq <= 1'b0;
    end else if (operation_mode_bits == `SITC_MODE_NORMAL) begin
      trunk_sync_status <= trunk_frame_ok;
      trunk_framing_irq <= trunk_frame_ok & ~trunk_sync_status & ~trunk_irq_mask;
    end else begin
      trunk_sync_status <= 1'b0;
      trunk_framing_irq <= 1'b0;
    end
  end

  // ****************************************
  // Pin drivers
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      trunk_data_out <= 1'b0;
      trunk_data_oe <= 1'b0;
    end else begin
      trunk_data_out <= trunk_bit_in;
      trunk_data_oe <= trunk_standby_release & ts_field[trunk_slot];
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cfg_data_out <= 1'b0;
      cfg_data_oe <= 1'b0;
    end else if (!cfg_if_standby_release) begin
      cfg_data_out <= 1'b0;
      cfg_data_oe <= 1'b0;
    end else if (!cfg_slot_active) begin
      // Open drain shows a one by letting go, never by driving high
      cfg_data_out <= output_style_bit;
      cfg_data_oe <= 1'b0;
    end else if (output_style_bit) begin
      cfg_data_out <= 1'b0;
      cfg_data_oe <= ~cfg_bit_in;
    end else begin
      cfg_data_out <= cfg_bit_in;
      cfg_data_oe <= 1'b1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      data_clock_out <= 1'b0;
      frame_sync_out <= 1'b0;
      data_clock_oe <= 1'b0;
      frame_sync_oe <= 1'b0;
    end else begin
      data_clock_out <= dclk_gen;
      frame_sync_out <= fsync_gen;
      data_clock_oe <= cfg_if_standby_release & dclk_is_output;
      frame_sync_oe <= cfg_if_standby_release & dclk_is_output;
    end
  end
endmodule // sitc_ctrl

// ===== testbench/sitc_ctrl_monitor.sv
`timescale 1ns/1ps
// ****************************************
// Control checker
// ****************************************
module sitc_ctrl_monitor #(
  parameter int TIMER_STEP_CYC = 10
) (
  input wire logic       ref_clk,
  input wire logic       rstn,
  input wire logic       reset_pin,
  input wire logic       cmd_wr,
  input wire logic [7:0] memory_command_reg,
  input wire logic [7:0] timer_period,
  input wire logic [1:0] operation_mode_bits,
  input wire logic       trunk_standby_release,
  input wire logic       cfg_if_standby_release,
  input wire logic       output_style_bit,
  input wire logic       memory_access_busy,
  input wire logic       timer_irq,
  input wire logic       data_clock_oe,
  input wire logic       frame_sync_oe,
  input wire logic       trunk_data_oe,
  input wire logic       cfg_data_out,
  input wire logic       cfg_data_oe
);
  logic [11:0] run_q;
  logic [15:0] gap_q;
  logic        ts_q;
  logic        seen_q;
  logic        take;
  logic        wr7;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  assign take = cmd_wr && reset_pin && !memory_access_busy;
  assign wr7  = memory_command_reg[7:4] == 4'h7 && memory_command_reg != 8'h70;
  // Run and gap lengths, so long counts need no long repetition
  always_ff @(posedge ref_clk) begin
    run_q  <= memory_access_busy ? run_q + 12'h001 : 12'h000;
    gap_q  <= timer_irq ? 16'h0000 : gap_q + 16'h0001;
    seen_q <= rstn && reset_pin && (seen_q || timer_irq);
    ts_q   <= rstn && (ts_q ? memory_access_busy : take && memory_command_reg == 8'h68 && operation_mode_bits == 2'b11);
  end
  sequence clear_run_s;
    ##1 memory_access_busy ##256 memory_access_busy ##1 !memory_access_busy;
  endsequence
  sequence slow_run_s;
    ##1 memory_access_busy [*5] ##1 !memory_access_busy;
  endsequence
  sequence fast_run_s;
    ##1 memory_access_busy [*3] ##1 !memory_access_busy or ##1 memory_access_busy [*4] ##1 !memory_access_busy;
  endsequence
  clear_time_a: assert property (take && memory_command_reg == 8'h70 && operation_mode_bits == 2'b00 |-> clear_run_s)
    else $error("clear busy length wrong");
  ts_time_a: assert property ($fell(memory_access_busy) && ts_q |-> run_q == 12'h40C)
    else $error("tristate init busy length wrong");
  ts_refuse_a: assert property (take && memory_command_reg == 8'h68 && operation_mode_bits != 2'b11
    |=> !memory_access_busy)
    else $error("refused tristate init set busy");
  slow_write_a: assert property (take && wr7 && operation_mode_bits == 2'b11 |-> slow_run_s)
    else $error("single write busy length wrong");
  fast_write_a: assert property (take && wr7 && operation_mode_bits == 2'b10 |-> fast_run_s)
    else $error("fast write busy length wrong");
  reset_quiet_a: assert property (disable iff (1'b0) !rstn |=> !memory_access_busy && !data_clock_oe && !frame_sync_oe)
    else $error("outputs active after reset");
  trunk_standby_a: assert property (!trunk_standby_release [*2] |-> !trunk_data_oe)
    else $error("trunk driver on in standby");
  cfg_standby_a: assert property (!cfg_if_standby_release [*2] |-> !cfg_data_oe && !data_clock_oe && !frame_sync_oe)
    else $error("interface driver on in standby");
  open_drain_a: assert property (output_style_bit [*3] ##0 cfg_data_oe |-> !cfg_data_out)
    else $error("open drain drives high");
  timer_gap_a: assert property (timer_irq && seen_q |-> int'(gap_q) == (int'(timer_period[6:0]) + 1) * TIMER_STEP_CYC - 1)
    else $error("timer period wrong");
endmodule // sitc_ctrl_monitor
bind sitc_ctrl sitc_ctrl_monitor #(.TIMER_STEP_CYC(TIMER_STEP_CYC)) i_sitc_ctrl_monitor (.ref_clk, .rstn, .reset_pin,
  .cmd_wr, .memory_command_reg, .timer_period, .operation_mode_bits, .trunk_standby_release, .cfg_if_standby_release,
  .output_style_bit, .memory_access_busy, .timer_irq, .data_clock_oe, .frame_sync_oe, .trunk_data_oe, .cfg_data_out,
  .cfg_data_oe);

// ===== testbench/sitc_host_model.sv
`timescale 1ns/1ps
// ****************************************
// Host processor model
// ****************************************
module sitc_host_model (
  // Clock
  input wire logic       ref_clk,
  // Command port
  output logic           cmd_wr,
  output logic [7:0]     memory_command_reg,
  output logic [7:0]     memory_address_reg,
  output logic [7:0]     memory_data_reg,
  // Status
  input wire logic       memory_access_busy
);
  initial begin
    cmd_wr = 1'b0;
    memory_command_reg = 8'h00;
    memory_address_reg = 8'h00;
    memory_data_reg = 8'h00;
  end
  // Data is not held after the write, so a stale value cannot pass
  task automatic pulse(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d);
    memory_command_reg = c;
    memory_address_reg = a;
    memory_data_reg = d;
    cmd_wr = 1'b1;
    @(posedge ref_clk);
    #1;
    cmd_wr = 1'b0;
    memory_data_reg = ~d;
  endtask
  // Returns busy length in cycles, -1 on a hang
  task automatic issue(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d, output int n);
    int k;
    n = 0;
    for (k = 0; k < 2000 && memory_access_busy !== 1'b0; k++) begin
      @(posedge ref_clk);
      #1;
    end
    @(posedge ref_clk);
    #1;
    pulse(c, a, d);
    for (k = 0; k < 2000 && memory_access_busy === 1'b1; k++) begin
      n++;
      @(posedge ref_clk);
      #1;
    end
    if (k == 2000) n = -1;
  endtask
endmodule // sitc_host_model

// ===== testbench/switch_init_timer_ctrl_tb.sv
`timescale 1ns/1ps
// ****************************************
// Control block bench
// ****************************************
module switch_init_timer_ctrl_tb;
  import sitc_pkg::*;
  logic ref_clk = 1'b0, trunk_clock = 1'b0, dclk_gen = 1'b0, fsync_gen = 1'b0;
  logic rstn, reset_pin, cfg_wr, supply_fail, trunk_frame_ok, trunk_irq_mask, trunk_bit_in, cfg_slot_active;
  logic cfg_bit_in, trunk_standby_release, cfg_if_standby_release, output_style_bit, trunk_test_loop;
  logic monitor_handshake_select, register_bank_select;
  logic [1:0] operation_mode_bits;
  logic [7:0] cfg_data, cfg_reg, memory_command_reg, memory_address_reg, memory_data_reg;
  logic [4:0] mode_flags;
  wire  logic cmd_wr, memory_access_busy, timer_irq, reinit_request, trunk_sync_status, data_clock_oe;
  wire  logic frame_sync_oe, trunk_data_oe, cfg_data_out, cfg_data_oe;
  wire  logic debounce_tick, multiframe_mark, trunk_framing_irq, data_clock_out;
  sitc_cm_word_t cm_rd_word;
  int   num_errors = 0, total_checks = 0, n, k;
  always #12.5 ref_clk = ~ref_clk;
  always #40 trunk_clock = ~trunk_clock;
  always @(posedge ref_clk) dclk_gen <= ~dclk_gen;
  sitc_host_model i_sitc_host_model (.ref_clk, .cmd_wr, .memory_command_reg, .memory_address_reg, .memory_data_reg,
    .memory_access_busy);
  sitc_ctrl #(.TIMER_STEP_CYC(10)) i_sitc_ctrl (.ref_clk, .rstn, .reset_pin, .trunk_clock, .cmd_wr,
    .memory_command_reg, .memory_address_reg, .memory_data_reg, .timer_period(8'h03), .operation_mode_bits,
    .trunk_standby_release, .cfg_if_standby_release, .output_style_bit, .trunk_test_loop, .monitor_handshake_select,
    .register_bank_select, .cfg_wr, .cfg_data, .supply_fail, .trunk_frame_ok, .trunk_irq_mask, .trunk_slot(7'h02),
    .trunk_bit_in, .cfg_slot_active, .cfg_bit_in, .dclk_gen, .fsync_gen, .dclk_is_output(1'b1),
    .memory_access_busy, .timer_irq, .debounce_tick, .multiframe_mark, .reinit_request, .trunk_framing_irq,
    .trunk_sync_status, .mode_flags, .cfg_reg, .data_clock_out, .data_clock_oe, .frame_sync_out(), .frame_sync_oe,
    .trunk_data_out(), .trunk_data_oe, .cfg_data_out, .cfg_data_oe, .cm_rd_word);
  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
    if (got === 12'hFFF && what == "busy") give_verdict;
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask
  task automatic t_config;
    operation_mode_bits = 2'b10;
    cfg_data = 8'h5A;
    cfg_wr = 1'b1;
    tick(1);
    cfg_wr = 1'b0;
    {output_style_bit, trunk_test_loop, register_bank_select} = 3'b111;
    tick(2);
    chk("cfg", 12'h05A, {4'h0, cfg_reg});
    chk("flags", 12'h015, {7'h00, mode_flags});
  endtask
  task automatic t_reset_pin;
    cfg_if_standby_release = 1'b1;
    reset_pin = 1'b0;
    tick(30);
    chk("clock out", 12'h000, {9'h000, data_clock_oe, frame_sync_oe, data_clock_out});
    reset_pin = 1'b1;
    tick(4);
    chk("cfg", 12'h000, {4'h0, cfg_reg});
    cfg_if_standby_release = 1'b0;
  endtask
  task automatic t_clear;
    supply_fail = 1'b1;
    tick(5);
    supply_fail = 1'b0;
    for (k = 0; k < 100 && reinit_request !== 1'b1; k++) tick(1);
    chk("reinit", 12'h001, {11'h000, reinit_request});
    operation_mode_bits = 2'b00;
    i_sitc_host_model.issue(8'h68, 8'h00, 8'h00, n);
    chk("busy", 12'h000, 12'(n));
    fork
      i_sitc_host_model.issue(8'h70, 8'h08, 8'hFF, n);
      begin
        tick(6);
        i_sitc_host_model.pulse(8'h78, 8'h08, 8'h00);
      end
    join
    chk("busy", 12'h101, 12'(n));
    tick(2);
    chk("code", 12'h000, {8'h00, cm_rd_word[11:8]});
    chk("reinit", 12'h000, {11'h000, reinit_request});
  endtask
  task automatic t_slots;
    operation_mode_bits = 2'b11;
    i_sitc_host_model.issue(8'h78, 8'h08, 8'hFF, n);
    chk("busy", 12'h005, 12'(n));
    tick(2);
    chk("word", 12'h8FF, cm_rd_word);
    i_sitc_host_model.issue(8'h78, 8'h88, 8'hFF, n);
    tick(2);
    chk("word", 12'h8FF, cm_rd_word);
    i_sitc_host_model.issue(8'h70, 8'h89, 8'hFF, n);
    chk("busy", 12'h005, 12'(n));
    tick(2);
    chk("word", 12'h0FF, cm_rd_word);
    operation_mode_bits = 2'b10;
    i_sitc_host_model.issue(8'h7B, 8'h09, 8'hFF, n);
    chk("busy", 12'h001, {11'h000, n == 3 || n == 4});
    tick(2);
    chk("word", 12'hBFF, cm_rd_word);
  endtask
  task automatic t_trunk;
    operation_mode_bits = 2'b11;
    i_sitc_host_model.issue(8'h68, 8'h00, 8'h0F, n);
    chk("busy", 12'h40C, 12'(n));
    for (k = 0; k < 100 && trunk_sync_status !== 1'b1; k++) tick(1);
    chk("sync", 12'h001, {11'h000, trunk_sync_status});
    trunk_frame_ok = 1'b0;
    tick(3);
    trunk_frame_ok = 1'b1;
    for (k = 0; k < 10 && trunk_framing_irq !== 1'b1; k++) tick(1);
    chk("framing irq", 12'h001, {11'h000, trunk_framing_irq});
    tick(3);
    chk("trunk oe", 12'h000, {11'h000, trunk_data_oe});
    trunk_standby_release = 1'b1;
    tick(3);
    chk("trunk oe", 12'h001, {11'h000, trunk_data_oe});
    i_sitc_host_model.issue(8'h68, 8'h00, 8'h00, n);
    chk("busy", 12'h40C, 12'(n));
    chk("trunk oe", 12'h000, {11'h000, trunk_data_oe});
  endtask
  task automatic t_cfg_if;
    cfg_if_standby_release = 1'b1;
    cfg_slot_active = 1'b1;
    tick(3);
    chk("oe out", 12'h002, {10'h000, cfg_data_oe, cfg_data_out});
    cfg_bit_in = 1'b1;
    tick(3);
    chk("oe", 12'h000, {11'h000, cfg_data_oe});
    output_style_bit = 1'b0;
    tick(3);
    chk("oe out", 12'h003, {10'h000, cfg_data_oe, cfg_data_out});
    cfg_slot_active = 1'b0;
    tick(3);
    chk("oe out", 12'h000, {10'h000, cfg_data_oe, cfg_data_out});
    output_style_bit = 1'b1;
    tick(3);
    chk("oe out", 12'h001, {10'h000, cfg_data_oe, cfg_data_out});
  endtask
  task automatic t_timer;
    for (k = 0; k < 200 && timer_irq !== 1'b1; k++) tick(1);
    tick(1);
    fsync_gen = 1'b1;
    tick(1);
    fsync_gen = 1'b0;
    chk("mark", 12'h000, {11'h000, multiframe_mark});
    for (k = 3; k < 200; k++) begin
      tick(1);
      if (timer_irq === 1'b1) break;
    end
    chk("gap", 12'h028, 12'(k));
    chk("debounce", 12'h001, {11'h000, debounce_tick});
    tick(1);
    chk("mark", 12'h001, {11'h000, multiframe_mark});
  endtask
  initial begin
    {rstn, cfg_wr, supply_fail, trunk_irq_mask, trunk_bit_in, cfg_slot_active, cfg_bit_in} = 7'h00;
    {trunk_standby_release, cfg_if_standby_release, output_style_bit, trunk_test_loop} = 4'h0;
    {monitor_handshake_select, register_bank_select, reset_pin, trunk_frame_ok} = 4'h3;
    operation_mode_bits = 2'b00;
    cfg_data = 8'h00;
    tick(10);
    rstn = 1'b1;
    // Initialization order: config, clear, slots, tristate, activate
    t_config;
    t_reset_pin;
    t_clear;
    t_slots;
    t_trunk;
    t_cfg_if;
    t_timer;
    give_verdict;
  end
endmodule // switch_init_timer_ctrl_tb
